// [rtl/dpu_pkg.sv]
// Package of constants for the diverse protection voting logic
package dpu_pkg;
   // =====================================================================
   // Geometry
   localparam int NUM_CHAN = 4;
   localparam int NUM_PROC = 3;
   localparam int NUM_RELIEF = 10;
   localparam int NUM_SCRAM_IN = 6;
   // =====================================================================
   // Scram input bit positions
   localparam int SCR_HI_PRESS = 0;
   localparam int SCR_HI_LVL8 = 1;
   localparam int SCR_LO_LVL3 = 2;
   localparam int SCR_HI_DW_PRESS = 3;
   localparam int SCR_HI_POOL_TEMP = 4;
   localparam int SCR_SIV_CLOSED = 5;
   // =====================================================================
   // Timing
   localparam longint CLK_HZ = 100000000;
   localparam int LVL1_HOLD_S = 10;
   localparam int INHIBIT_HOLD_S = 60;
   localparam int RUNBACK_DELAY_S = 10;
   localparam longint LVL1_HOLD_CYC = LVL1_HOLD_S * CLK_HZ;
   localparam longint INHIBIT_HOLD_CYC = INHIBIT_HOLD_S * CLK_HZ;
   localparam longint RUNBACK_DELAY_CYC = RUNBACK_DELAY_S * CLK_HZ;
   localparam int TIMER_W = 40;
   // =====================================================================
   // Reset values
   localparam logic RST_BIT = 1'b0;
   localparam logic [2:0] RST_VEC3 = 3'h0;
   localparam logic [9:0] RST_RELIEF = 10'h000;
   localparam logic [TIMER_W-1:0] RST_CNT = 40'h00_0000_0000;
endpackage : dpu_pkg

// [rtl/dpu_vote.sv]
// Channel vote with bypass degradation
`timescale 1ns/1ps
`default_nettype none
module dpu_vote (
   input wire logic [3:0] chan_trip,
   input wire logic [3:0] chan_bad,
   output logic vote
);
   logic [3:0] good;
   logic [2:0] n_trip;
   logic [2:0] n_good;
   always_comb begin
      good = ~chan_bad;
      n_trip = 3'h0;
      n_good = 3'h0;
      for (int i = 0; i < 4; i++) begin
         n_trip = n_trip + {2'h0, chan_trip[i] & good[i]};
         n_good = n_good + {2'h0, good[i]};
      end
      // Two of four, or two of three remaining once a channel drops out
      // With two channels lost trip is two of two; with three lost the one survivor trips alone
      vote = (n_trip >= 3'h2) || ((n_good <= 3'h1) && (n_trip >= n_good) && (n_good != 3'h0));
   end
endmodule // dpu_vote
`default_nettype wire

// [rtl/dpu_timer.sv]
// Persistence timer: asserts once its condition has held for HOLD cycles
`timescale 1ns/1ps
`default_nettype none
module dpu_timer #(
   parameter longint HOLD = 64'd1000
) (
   input wire logic REF_CLK,
   input wire logic RESETN,
   input wire logic cond,
   output logic done
);
   logic [dpu_pkg::TIMER_W-1:0] cnt_q, cnt_d;
   always_comb begin
      if (!cond) begin
         cnt_d = dpu_pkg::RST_CNT;
      end else if (cnt_q < HOLD[dpu_pkg::TIMER_W-1:0]) begin
         cnt_d = cnt_q + 40'h00_0000_0001;
      end else begin
         cnt_d = cnt_q;
      end
      done = cond && (cnt_q >= HOLD[dpu_pkg::TIMER_W-1:0]);
   end
   always_ff @(posedge REF_CLK) begin
      if (!RESETN) begin
         cnt_q <= dpu_pkg::RST_CNT;
      end else begin
         cnt_q <= cnt_d;
      end
   end
endmodule // dpu_timer
`default_nettype wire

// [rtl/dpu_top.sv]
// Diverse protection unit: scram, runback, core cooling and inhibit logic
// Summary of operation
// - Diverse scram and rod insertion on voted rod-runin with power, or primary scram.
// - Delayed feedwater runback after diverse scram only while power stays elevated.
// - Failure-to-scram runback request is forwarded to the feedwater controller.
// - Feedwater pumps trip on very high level, Level 9.
// - Any of six plant conditions demands the diverse scram.
// - Bad or bypassed channel degrades channel vote to two of three.
// - Failed processor degrades output vote to two of two survivors.
// - Scram output switches the solenoid return side, energize to actuate.
// - Each processor sends its own scram link; timing panel votes two of three.
// - Manual scram accepted from hardwired switches or operator display.
// - Core cooling start from Level 1 channels voted two of four.
// - Level 1 held ten seconds latches and issues core cooling start.
// - Manual core cooling needs both operator inputs together.
// - Start signal needs two of three processors agreeing.
// - Actuation only when every series output switch confirms initiation.
// - No automatic sequenced initiation on drywell pressure; operator triggers it.
// - Fourth solenoid of all ten relief valves is driven.
// - Depressurization squib fires only on three simultaneous redundant trips.
// - Gravity injection squib needs three simultaneous trip signals.
// - Level 1 logic inhibited by Level 2 with flux, or pressure with flux 60 s.
// - Same inhibit blocks sequenced initiation and drywell feedwater isolation.
// - Operator inhibits for Level 1, sequenced initiation and feedwater isolation.
`timescale 1ns/1ps
`default_nettype none
module dpu_top (
   input wire logic REF_CLK,
   input wire logic RESETN,
   input wire logic [23:0] SCRAM_CHAN,
   input wire logic [3:0] CHAN_BAD,
   input wire logic [2:0] PROC_FAIL,
   input wire logic [2:0] RUNIN_CMD,
   input wire logic [3:0] PRIMARY_SCRAM,
   input wire logic POWER_HIGH,
   input wire logic RUNBACK_REQ,
   input wire logic [3:0] LVL9_CHAN,
   input wire logic [3:0] LVL1_CHAN,
   input wire logic [3:0] LVL2_CHAN,
   input wire logic [3:0] HI_PRESS_CHAN,
   input wire logic [3:0] FLUX_PERMIT_CHAN,
   input wire logic [3:0] DW_PRESS_HH_CHAN,
   input wire logic MAN_SCRAM_SW,
   input wire logic MAN_SCRAM_DISP,
   input wire logic [1:0] MAN_ECC,
   input wire logic MAN_SEQ_INIT,
   input wire logic MAN_INH_LVL1,
   input wire logic MAN_INH_SEQ,
   input wire logic MAN_INH_FWISO,
   input wire logic [2:0] SWITCH_OK,
   output logic SCRAM_RETURN_OPEN,
   output logic [2:0] SCRAM_LINK,
   output logic ROD_INSERT,
   output logic FW_RUNBACK,
   output logic FW_PUMP_TRIP,
   output logic FW_ISOLATE,
   output logic ECC_START,
   output logic [9:0] RELIEF_SOL,
   output logic [2:0] DEPRESS_TRIP,
   output logic [2:0] GRAVITY_TRIP,
   output logic INHIBIT_ACTIVE
);
   // =====================================================================
   // Input synchronisers: every input pin but REF_CLK and RESETN passes two flops before use
   localparam int IN_W = 24 + 4 + 3 + 3 + 4 + 1 + 1 + 4 * 6 + 1 + 1 + 2 + 1 + 1 + 1 + 1 + 3;
   logic [IN_W-1:0] raw, s1_q, s2_q;
   assign raw = {SCRAM_CHAN, CHAN_BAD, PROC_FAIL, RUNIN_CMD, PRIMARY_SCRAM, POWER_HIGH,
                 RUNBACK_REQ, LVL9_CHAN, LVL1_CHAN, LVL2_CHAN, HI_PRESS_CHAN,
                 FLUX_PERMIT_CHAN, DW_PRESS_HH_CHAN, MAN_SCRAM_SW, MAN_SCRAM_DISP,
                 MAN_ECC, MAN_SEQ_INIT, MAN_INH_LVL1, MAN_INH_SEQ, MAN_INH_FWISO,
                 SWITCH_OK};
   always_ff @(posedge REF_CLK) begin
      if (!RESETN) begin
         s1_q <= '0;
         s2_q <= '0;
      end else begin
         s1_q <= raw;
         s2_q <= s1_q;
      end
   end
   logic [23:0] scram_chan;
   logic [3:0] chan_bad, primary, lvl9, lvl1, lvl2, hi_press, flux, dw_hh;
   logic [2:0] proc_fail, runin, sw_ok;
   logic [1:0] man_ecc;
   logic power_high, runback_req, man_scr_sw, man_scr_disp, man_seq;
   logic inh_lvl1, inh_seq, inh_fwiso;
   assign {scram_chan, chan_bad, proc_fail, runin, primary, power_high, runback_req, lvl9,
           lvl1, lvl2, hi_press, flux, dw_hh, man_scr_sw, man_scr_disp, man_ecc, man_seq,
           inh_lvl1, inh_seq, inh_fwiso, sw_ok} = s2_q;

   // Two of three among live processors; two of two once one has failed
   function automatic logic proc_vote(input logic [2:0] d, input logic [2:0] fail);
      logic [2:0] live;
      logic [1:0] n_live, n_trip;
      live = ~fail;
      n_live = 2'(live[0]) + 2'(live[1]) + 2'(live[2]);
      n_trip = 2'(d[0] & live[0]) + 2'(d[1] & live[1]) + 2'(d[2] & live[2]);
      if (n_live == 2'h3) begin
         proc_vote = n_trip >= 2'h2;
      end else begin
         proc_vote = (n_trip == n_live) && (n_live != 2'h0);
      end
   endfunction

   // =====================================================================
   // Channel votes, one set shared by all processors
   logic [5:0] scr_vote;
   logic lvl9_v, lvl1_v, lvl2_v, press_v, flux_v, dwhh_v, prim_v;
   genvar g;
   generate
      for (g = 0; g < dpu_pkg::NUM_SCRAM_IN; g++) begin : g_scr
         dpu_vote u_v (
            .chan_trip(scram_chan[4*g +: 4]),
            .chan_bad(chan_bad),
            .vote(scr_vote[g])
         );
      end
   endgenerate
   dpu_vote u_prim (.chan_trip(primary), .chan_bad(chan_bad), .vote(prim_v));
   dpu_vote u_l9 (.chan_trip(lvl9), .chan_bad(chan_bad), .vote(lvl9_v));
   dpu_vote u_l1 (.chan_trip(lvl1), .chan_bad(chan_bad), .vote(lvl1_v));
   dpu_vote u_l2 (.chan_trip(lvl2), .chan_bad(chan_bad), .vote(lvl2_v));
   dpu_vote u_hp (.chan_trip(hi_press), .chan_bad(chan_bad), .vote(press_v));
   dpu_vote u_fx (.chan_trip(flux), .chan_bad(chan_bad), .vote(flux_v));
   dpu_vote u_dw (.chan_trip(dw_hh), .chan_bad(chan_bad), .vote(dwhh_v));

   // =====================================================================
   // Inhibit and persistence timers
   logic press_flux_done, lvl1_done, runback_done, inhibit;
   dpu_timer #(.HOLD(dpu_pkg::INHIBIT_HOLD_CYC)) u_tinh (
      .REF_CLK(REF_CLK),
      .RESETN(RESETN),
      .cond(press_v & flux_v),
      .done(press_flux_done)
   );
   assign inhibit = (lvl2_v & flux_v) | press_flux_done;

   logic lvl1_cond;
   assign lvl1_cond = lvl1_v & ~inhibit & ~inh_lvl1;
   dpu_timer #(.HOLD(dpu_pkg::LVL1_HOLD_CYC)) u_tl1 (
      .REF_CLK(REF_CLK),
      .RESETN(RESETN),
      .cond(lvl1_cond),
      .done(lvl1_done)
   );

   // =====================================================================
   // Scram and core cooling state
   logic scram_latch_q, scram_latch_d;
   logic ecc_seal_q, ecc_seal_d;
   logic scram_dem;
   dpu_timer #(.HOLD(dpu_pkg::RUNBACK_DELAY_CYC)) u_trb (
      .REF_CLK(REF_CLK),
      .RESETN(RESETN),
      .cond(scram_latch_q & power_high),
      .done(runback_done)
   );

   // Each processor computes the same decision from shared channel data
   logic [2:0] proc_scram, proc_ecc, proc_seq;
   logic scr_auto, ecc_auto, ecc_man, seq_ok;
   always_comb begin
      scr_auto = (|scr_vote) | prim_v | (proc_vote(runin, proc_fail) & power_high);
      ecc_auto = lvl1_done | ecc_seal_q;
      ecc_man = man_ecc[0] & man_ecc[1];
      seq_ok = man_seq & ~inhibit & ~inh_seq;
      proc_scram = {3{scr_auto | man_scr_sw | man_scr_disp}} & ~proc_fail;
      proc_ecc = {3{ecc_auto | ecc_man}} & ~proc_fail;
      proc_seq = {3{seq_ok}} & ~proc_fail;
      scram_dem = proc_vote(proc_scram, proc_fail);
      scram_latch_d = scram_latch_q | scram_dem;
      ecc_seal_d = ecc_seal_q | lvl1_done;
   end

   // =====================================================================
   // Output stage: next values here, plain registers below
   logic ecc_voted, seq_voted, actuate, seq_act, fire;
   logic scram_out_d, rod_d, runback_d, pump_trip_d, isolate_d;
   logic ecc_start_d, inhibit_d;
   logic [2:0] link_d;
   logic [9:0] relief_d;
   logic [2:0] depress_d, gravity_d;
   always_comb begin
      ecc_voted = proc_vote(proc_ecc, proc_fail);
      seq_voted = proc_vote(proc_seq, proc_fail);
      actuate = ecc_voted & (&sw_ok);
      seq_act = seq_voted & (&sw_ok);
      fire = actuate | seq_act;
      // Trip sits on the solenoid return leg so the supply side stays untouched
      scram_out_d = scram_dem;
      rod_d = scram_dem;
      link_d = proc_scram;
      runback_d = runback_req | runback_done;
      pump_trip_d = lvl9_v;
      isolate_d = dwhh_v & ~inhibit & ~inh_fwiso;
      ecc_start_d = actuate;
      relief_d = {dpu_pkg::NUM_RELIEF{fire}};
      // Three separate trip paths feed each squib; one bad path cannot fire it
      depress_d = {3{fire}};
      gravity_d = {3{fire}};
      inhibit_d = inhibit;
   end

   always_ff @(posedge REF_CLK) begin
      if (!RESETN) begin
         scram_latch_q <= dpu_pkg::RST_BIT;
         ecc_seal_q <= dpu_pkg::RST_BIT;
         SCRAM_RETURN_OPEN <= dpu_pkg::RST_BIT;
         SCRAM_LINK <= dpu_pkg::RST_VEC3;
         ROD_INSERT <= dpu_pkg::RST_BIT;
         FW_RUNBACK <= dpu_pkg::RST_BIT;
         FW_PUMP_TRIP <= dpu_pkg::RST_BIT;
         FW_ISOLATE <= dpu_pkg::RST_BIT;
         ECC_START <= dpu_pkg::RST_BIT;
         RELIEF_SOL <= dpu_pkg::RST_RELIEF;
         DEPRESS_TRIP <= dpu_pkg::RST_VEC3;
         GRAVITY_TRIP <= dpu_pkg::RST_VEC3;
         INHIBIT_ACTIVE <= dpu_pkg::RST_BIT;
      end else begin
         scram_latch_q <= scram_latch_d;
         ecc_seal_q <= ecc_seal_d;
         SCRAM_RETURN_OPEN <= scram_out_d;
         SCRAM_LINK <= link_d;
         ROD_INSERT <= rod_d;
         FW_RUNBACK <= runback_d;
         FW_PUMP_TRIP <= pump_trip_d;
         FW_ISOLATE <= isolate_d;
         ECC_START <= ecc_start_d;
         RELIEF_SOL <= relief_d;
         DEPRESS_TRIP <= depress_d;
         GRAVITY_TRIP <= gravity_d;
         INHIBIT_ACTIVE <= inhibit_d;
      end
   end
endmodule // dpu_top
`default_nettype wire

// [bench/dpu_chk.sv]
// Port-level assertions for the diverse protection unit
`timescale 1ns/1ps
`default_nettype none
module dpu_chk (
   input wire logic REF_CLK,
   input wire logic RESETN,
   input wire logic [23:0] SCRAM_CHAN,
   input wire logic [3:0] CHAN_BAD,
   input wire logic [2:0] PROC_FAIL,
   input wire logic [3:0] LVL9_CHAN,
   input wire logic RUNBACK_REQ,
   input wire logic MAN_INH_SEQ,
   input wire logic [2:0] SWITCH_OK,
   input wire logic SCRAM_RETURN_OPEN,
   input wire logic ROD_INSERT,
   input wire logic FW_RUNBACK,
   input wire logic FW_PUMP_TRIP,
   input wire logic ECC_START,
   input wire logic [9:0] RELIEF_SOL,
   input wire logic [2:0] DEPRESS_TRIP,
   input wire logic FW_ISOLATE,
   input wire logic INHIBIT_ACTIVE
);
   // ==========================================================
   // Warm-up count: $past looks 3 edges back, past any reset
   logic [2:0] up_q;
   logic [2:0] up_d;
   logic up;
   always_comb begin
      up_d = RESETN ? up_q + {2'h0, up_q != 3'h4} : 3'h0;
      up = up_q == 3'h4;
   end
   always_ff @(posedge REF_CLK) begin
      up_q <= up_d;
   end
   default clocking @(posedge REF_CLK); endclocking
   default disable iff (!RESETN);
   // ==========================================================
   // Checks
   property p_vote;
      up && $past(CHAN_BAD == 4'h0 && $countones(PROC_FAIL) < 2 &&
         $countones(SCRAM_CHAN[3:0]) > 1, 3) |-> SCRAM_RETURN_OPEN;
   endproperty
   a_vote: assert property (p_vote) else $error("scram vote missed");
   property p_latch;
      SCRAM_RETURN_OPEN |=> SCRAM_RETURN_OPEN;
   endproperty
   a_latch: assert property (p_latch) else $error("scram dropped");
   property p_rod;
      SCRAM_RETURN_OPEN |-> ROD_INSERT;
   endproperty
   a_rod: assert property (p_rod) else $error("rod insert missing");
   property p_trip;
      up && $past(CHAN_BAD == 4'h0 && $countones(LVL9_CHAN) > 1, 3) |-> FW_PUMP_TRIP;
   endproperty
   a_trip: assert property (p_trip) else $error("pump trip missing");
   property p_notrip;
      up && $past(CHAN_BAD == 4'h0 && $countones(LVL9_CHAN) < 2, 3) |-> !FW_PUMP_TRIP;
   endproperty
   a_notrip: assert property (p_notrip) else $error("pump trip early");
   property p_fwd;
      up && $past(RUNBACK_REQ && $countones(PROC_FAIL) < 2, 3) |-> FW_RUNBACK;
   endproperty
   a_fwd: assert property (p_fwd) else $error("runback not sent");
   property p_sw;
      up && ECC_START |-> $past(SWITCH_OK, 3) == 3'h7;
   endproperty
   a_sw: assert property (p_sw) else $error("start without switches");
   property p_inh;
      up && $past(MAN_INH_SEQ, 3) && !ECC_START |-> RELIEF_SOL == 10'h000 && DEPRESS_TRIP == 3'h0;
   endproperty
   a_inh: assert property (p_inh) else $error("inhibit ignored");
   property p_iso;
      INHIBIT_ACTIVE |-> !FW_ISOLATE;
   endproperty
   a_iso: assert property (p_iso) else $error("isolation not inhibited");
endmodule // dpu_chk
bind dpu_top dpu_chk dpu_chk_i (.REF_CLK(REF_CLK), .RESETN(RESETN), .SCRAM_CHAN(SCRAM_CHAN),
   .CHAN_BAD(CHAN_BAD), .PROC_FAIL(PROC_FAIL), .LVL9_CHAN(LVL9_CHAN), .RUNBACK_REQ(RUNBACK_REQ),
   .MAN_INH_SEQ(MAN_INH_SEQ), .SWITCH_OK(SWITCH_OK), .SCRAM_RETURN_OPEN(SCRAM_RETURN_OPEN),
   .ROD_INSERT(ROD_INSERT), .FW_RUNBACK(FW_RUNBACK), .FW_PUMP_TRIP(FW_PUMP_TRIP),
   .ECC_START(ECC_START), .RELIEF_SOL(RELIEF_SOL), .DEPRESS_TRIP(DEPRESS_TRIP),
   .FW_ISOLATE(FW_ISOLATE), .INHIBIT_ACTIVE(INHIBIT_ACTIVE));
`default_nettype wire

// [bench/dpu_switch_model.sv]
// Model of the series output switches on the actuation side
`timescale 1ns/1ps
`default_nettype none
module dpu_switch_model (
   input wire logic clk,
   input wire logic [2:0] ok_cmd,
   output logic [2:0] switch_ok
);
   // Each switch confirms on its own, one clock late like real relays
   always_ff @(posedge clk) begin
      switch_ok <= ok_cmd;
   end
endmodule // dpu_switch_model
`default_nettype wire

// [bench/testbench.sv]
// Self-checking testbench for the diverse protection unit
`timescale 1ns/1ps
`default_nettype none
module testbench;
   typedef struct packed {
      logic [23:0] scram;
      logic [3:0] bad, prim, lvl9, lvl2, flux, lvl1, hp, dwhh;
      logic [2:0] pfail, runin;
      logic [1:0] mecc;
      logic pwr, rbq, msw, mdisp, seq, inh, mfwiso;
   } dpu_stim_s;
   dpu_stim_s st;
   logic REF_CLK, RESETN, SCRAM_RETURN_OPEN, ROD_INSERT, FW_RUNBACK, FW_PUMP_TRIP, ECC_START;
   logic INHIBIT_ACTIVE, FW_ISOLATE;
   logic [2:0] SCRAM_LINK, DEPRESS_TRIP, GRAVITY_TRIP, SWITCH_OK, ok_cmd;
   logic [9:0] RELIEF_SOL;
   int n_errors = 0;
   int checked = 0;
   int cyc = 0;
   int k;
   dpu_switch_model dpu_switch_model_i (.clk(REF_CLK), .ok_cmd(ok_cmd), .switch_ok(SWITCH_OK));
   dpu_top dpu_top_i (.REF_CLK(REF_CLK), .RESETN(RESETN), .SCRAM_CHAN(st.scram),
      .CHAN_BAD(st.bad), .PROC_FAIL(st.pfail), .RUNIN_CMD(st.runin), .PRIMARY_SCRAM(st.prim),
      .POWER_HIGH(st.pwr), .RUNBACK_REQ(st.rbq), .LVL9_CHAN(st.lvl9), .LVL1_CHAN(st.lvl1),
      .LVL2_CHAN(st.lvl2), .HI_PRESS_CHAN(st.hp), .FLUX_PERMIT_CHAN(st.flux),
      .DW_PRESS_HH_CHAN(st.dwhh), .MAN_SCRAM_SW(st.msw), .MAN_SCRAM_DISP(st.mdisp),
      .MAN_ECC(st.mecc), .MAN_SEQ_INIT(st.seq), .MAN_INH_LVL1(1'b0), .MAN_INH_SEQ(st.inh),
      .MAN_INH_FWISO(st.mfwiso), .SWITCH_OK(SWITCH_OK), .SCRAM_RETURN_OPEN(SCRAM_RETURN_OPEN),
      .SCRAM_LINK(SCRAM_LINK), .ROD_INSERT(ROD_INSERT), .FW_RUNBACK(FW_RUNBACK),
      .FW_PUMP_TRIP(FW_PUMP_TRIP), .FW_ISOLATE(FW_ISOLATE), .ECC_START(ECC_START),
      .RELIEF_SOL(RELIEF_SOL), .DEPRESS_TRIP(DEPRESS_TRIP), .GRAVITY_TRIP(GRAVITY_TRIP),
      .INHIBIT_ACTIVE(INHIBIT_ACTIVE));
   // ==========================================================
   // Helpers
   task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
      checked++;
      if (seen !== exp) begin
         n_errors++;
         $display("ERROR %s expected %h seen %h", what, exp, seen);
      end
   endtask
   // Inputs pass two sync flops and an output register, so 5 edges is ample
   task automatic settle;
      repeat (5) @(posedge REF_CLK);
      #1;
   endtask
   task automatic do_reset;
      @(posedge REF_CLK);
      RESETN <= 1'b0;
      st <= '0;
      ok_cmd <= 3'h7;
      repeat (20) @(posedge REF_CLK);
      RESETN <= 1'b1;
      repeat (3) @(posedge REF_CLK);
   endtask
   task automatic give_verdict;
      $display("comparisons %0d mismatches %0d", checked, n_errors);
      if (n_errors == 0 && checked > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask
   // ==========================================================
   // Clock and watchdog
   initial begin
      REF_CLK = 1'b0;
      forever #5 REF_CLK = ~REF_CLK;
   end
   always @(posedge REF_CLK) begin
      cyc++;
      if (cyc == 3000) begin
         n_errors++;
         give_verdict;
      end
   end
   // ==========================================================
   // Tests
   initial begin
      RESETN = 1'b0;
      st = '0;
      ok_cmd = 3'h7;
      for (k = 0; k < 6; k++) begin
         do_reset;
         st.scram[4*k+2] <= 1'b1;
         settle;
         chk("scram one chan", SCRAM_RETURN_OPEN, 0);
         @(posedge REF_CLK);
         st.scram[4*k+3] <= 1'b1;
         settle;
         chk("scram", {ROD_INSERT, SCRAM_RETURN_OPEN, SCRAM_LINK}, 5'h1F);
      end
      $display("test scram inputs done");
      do_reset;
      st.bad <= 4'h1;
      st.pfail <= 3'h4;
      st.scram[1:0] <= 2'h3;
      settle;
      chk("bad chan", SCRAM_RETURN_OPEN, 0);
      @(posedge REF_CLK);
      st.scram[2] <= 1'b1;
      settle;
      chk("degraded vote", {SCRAM_LINK, SCRAM_RETURN_OPEN}, 4'h7);
      $display("test degraded votes done");
      for (k = 0; k < 5; k++) begin
         do_reset;
         case (k)
            0: st.prim <= 4'h9;
            1: st.runin <= 3'h6;
            2: st.runin <= 3'h5;
            3: st.msw <= 1'b1;
            default: st.mdisp <= 1'b1;
         endcase
         st.pwr <= k == 2;
         settle;
         chk("scram source", {ROD_INSERT, SCRAM_RETURN_OPEN}, {2{k != 1}});
         chk("runback delayed", FW_RUNBACK, 0);
      end
      $display("test scram sources done");
      do_reset;
      st.lvl9 <= 4'h8;
      st.rbq <= 1'b1;
      settle;
      chk("fw one chan", {FW_PUMP_TRIP, FW_RUNBACK}, 2'h1);
      @(posedge REF_CLK);
      st.lvl9 <= 4'hC;
      st.rbq <= 1'b0;
      settle;
      chk("fw trip", {FW_PUMP_TRIP, FW_RUNBACK}, 2'h2);
      @(posedge REF_CLK);
      st.lvl1 <= 4'h3;
      st.hp <= 4'h3;
      st.flux <= 4'h3;
      settle;
      chk("lvl1 short", ECC_START, 0);
      chk("press flux short", INHIBIT_ACTIVE, 0);
      $display("test feedwater done");
      do_reset;
      st.mecc <= 2'h1;
      settle;
      chk("ecc one input", ECC_START, 0);
      @(posedge REF_CLK);
      st.mecc <= 2'h3;
      settle;
      chk("ecc manual", ECC_START, 1);
      @(posedge REF_CLK);
      ok_cmd <= 3'h6;
      settle;
      chk("ecc switch open", ECC_START, 0);
      @(posedge REF_CLK);
      st.mecc <= 2'h0;
      ok_cmd <= 3'h7;
      st.seq <= 1'b1;
      st.dwhh <= 4'h3;
      settle;
      chk("seq init", {GRAVITY_TRIP, DEPRESS_TRIP, RELIEF_SOL}, 16'hFFFF);
      chk("fw isolate", FW_ISOLATE, 1);
      @(posedge REF_CLK);
      st.inh <= 1'b1;
      st.mfwiso <= 1'b1;
      settle;
      chk("seq manual inhibit", {GRAVITY_TRIP, DEPRESS_TRIP, RELIEF_SOL}, 16'h0000);
      chk("fw manual inhibit", FW_ISOLATE, 0);
      @(posedge REF_CLK);
      st.inh <= 1'b0;
      st.mfwiso <= 1'b0;
      st.lvl2 <= 4'h3;
      st.flux <= 4'h3;
      settle;
      chk("seq auto inhibit", {INHIBIT_ACTIVE, RELIEF_SOL}, 16'h0400);
      chk("fw auto inhibit", FW_ISOLATE, 0);
      $display("test core cooling done");
      give_verdict;
   end
endmodule // testbench
`default_nettype wire
